// ==== verilog/lcp_pkg.sv ====
// Purpose: shared constants for the line output and charge pump control block
// Assumes: AXI4-Lite with 32-bit data, one word per register
// Notes: register byte address is four times the register index
package lcp_pkg;
  // ****************
  // register map
  // ****************
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] LINEOUT_INDEX = 8'h5e;
  localparam logic [7:0] PUMP_ENABLE_INDEX = 8'h62;
  localparam logic [7:0] PUMP_MODE_INDEX = 8'h68;
  localparam logic [7:0] PUMP_STATUS_INDEX = 8'h69;
  localparam logic [ADDR_W-1:0] LINEOUT_ADDR = {2'b00, LINEOUT_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] PUMP_ENABLE_ADDR = {2'b00, PUMP_ENABLE_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] PUMP_MODE_ADDR = {2'b00, PUMP_MODE_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] PUMP_STATUS_ADDR = {2'b00, PUMP_STATUS_INDEX, 2'b00};
  // ****************
  // field positions and reset values
  // ****************
  localparam int unsigned LEFT_SHORT_BIT = 7;
  localparam int unsigned LEFT_OUTPUT_BIT = 6;
  localparam int unsigned LEFT_MIDDLE_BIT = 5;
  localparam int unsigned LEFT_INPUT_BIT = 4;
  localparam int unsigned RIGHT_SHORT_BIT = 3;
  localparam int unsigned RIGHT_OUTPUT_BIT = 2;
  localparam int unsigned RIGHT_MIDDLE_BIT = 1;
  localparam int unsigned RIGHT_INPUT_BIT = 0;
  localparam int unsigned PUMP_ENABLE_BIT = 0;
  localparam int unsigned PUMP_TRACK_BIT = 0;
  localparam int unsigned STATUS_RUN_BIT = 0;
  localparam int unsigned STATUS_RAIL_BIT = 1;
  localparam int unsigned STATUS_RATIO_LSB = 2;
  localparam logic [7:0] LINEOUT_RESET = 8'h00;
  localparam logic PUMP_ENABLE_RESET = 1'b0;
  localparam logic PUMP_TRACK_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ****************
  // clocking
  // ****************
  localparam int unsigned SYSCLK_HZ = 50_000_000;
  localparam int unsigned SYSCLK_MIN_HZ = 2_822_400;
  localparam int unsigned PUMP_NOMINAL_HZ = 1_000_000;
  localparam int unsigned TICK_HZ = 4_000;
  localparam int unsigned PUMP_PER_TICK = PUMP_NOMINAL_HZ / TICK_HZ;
  localparam int unsigned RATIO_W = 6;
  localparam logic [RATIO_W-1:0] RATIO_256FS = 6'h0c;
  localparam logic [RATIO_W-1:0] RATIO_128FS = 6'h06;
  localparam logic [RATIO_W-1:0] RATIO_STEP = RATIO_128FS >> 1;
  localparam logic [3:0] RATE_CODE_256FS = 4'h3;
  // ****************
  // pump rail states
  // ****************
  typedef enum logic [1:0] {
    LCP_RAIL_LOW = 2'b01,
    LCP_RAIL_FULL = 2'b10
  } lcp_rail_type;
endpackage : lcp_pkg

// ==== verilog/lcp_pump_if.sv ====
// Purpose: carries pump control between the register block and its helpers
// Assumes: all members sit on the system clock
// Notes: none
`timescale 1ns/1ns
interface lcp_pump_if;
  import lcp_pkg::*;
  logic enable;
  logic tracking;
  logic [RATIO_W-1:0] ratio;
  logic pump_pulse;
  logic pump_clock;
  logic tick;
  lcp_rail_type rail;
  modport ctrl (output enable, output tracking, output ratio,
                input pump_pulse, input pump_clock, input tick, input rail);
  modport divider (input enable, input ratio, input rail,
                   output pump_pulse, output pump_clock, output tick);
  modport level (input enable, input tracking, input tick, output rail);
endinterface : lcp_pump_if

// ==== verilog/lcp_clock_divider.sv ====
// Purpose: divides the system clock down to the pump clock and the slow tick
// Assumes: enable, ratio and rail come from the system clock domain
// Notes: low rail skips every other pump period to halve switching
`timescale 1ns/1ns
module lcp_clock_divider
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pump control
  lcp_pump_if.divider pump
);
  import lcp_pkg::*;
  logic [RATIO_W-1:0] count;
  logic [8:0] tick_count;
  logic skip;
  wire wrap = (count >= pump.ratio - 6'h01);
  wire tick_wrap = (tick_count == 9'(PUMP_PER_TICK - 1));
  // ****************
  // divider
  // ****************
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pump.enable)
    begin
      count <= '0;
      tick_count <= '0;
      skip <= 1'b0;
      pump.pump_pulse <= 1'b0;
      pump.pump_clock <= 1'b0;
      pump.tick <= 1'b0;
    end
    else
    begin
      count <= wrap ? '0 : count + 6'h01;
      pump.pump_pulse <= wrap && !skip;
      pump.pump_clock <= (count < (pump.ratio >> 1)) && !skip;
      if (wrap)
      begin
        skip <= (pump.rail == LCP_RAIL_LOW) ? !skip : 1'b0;
        tick_count <= tick_wrap ? '0 : tick_count + 9'h001;
      end
      pump.tick <= wrap && tick_wrap;
    end
  end
endmodule : lcp_clock_divider

// ==== verilog/lcp_level_mode.sv ====
// Purpose: chooses the pump rail level from volumes or from the audio level
// Assumes: volumes and audio level are on the system clock
// Notes: decision refreshed only on the slow tick to avoid rail chatter
`timescale 1ns/1ns
module lcp_level_mode
#(
  parameter int unsigned VOL_W = 6,
  parameter logic [5:0] VOL_FULL_LIMIT = 6'h30,
  parameter logic [7:0] LEVEL_FULL_LIMIT = 8'h40
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // level sources
  input wire logic [VOL_W-1:0] left_headphone_volume,
  input wire logic [VOL_W-1:0] right_headphone_volume,
  input wire logic [VOL_W-1:0] left_line_volume,
  input wire logic [VOL_W-1:0] right_line_volume,
  input wire logic [7:0] audio_level,
  // pump control
  lcp_pump_if.level pump
);
  import lcp_pkg::*;
  wire vol_full = (left_headphone_volume >= VOL_FULL_LIMIT) ||
                  (right_headphone_volume >= VOL_FULL_LIMIT) ||
                  (left_line_volume >= VOL_FULL_LIMIT) ||
                  (right_line_volume >= VOL_FULL_LIMIT);
  wire level_full = (audio_level >= LEVEL_FULL_LIMIT);
  wire want_full = pump.tracking ? level_full : vol_full;
  // ****************
  // rail decision
  // ****************
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pump.enable)
    begin
      pump.rail <= LCP_RAIL_LOW;
    end
    else if (pump.tick)
    begin
      pump.rail <= want_full ? LCP_RAIL_FULL : LCP_RAIL_LOW;
    end
  end
endmodule : lcp_level_mode

// ==== verilog/lcp_control.sv ====
// Purpose: line output stage control and charge pump control registers
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: stage bits are driven as written; pop-free order is software's job
//
// Notes on behaviour
// - left short-release bit 7; zero keeps left line shorted; resets zero.
// - left line output, middle, input stage enables at bits 6,5,4; reset zero.
// - right short-release bit 3; zero keeps right line shorted; resets zero.
// - right line output, middle, input stage enables at bits 2,1,0; reset zero.
// - pump runs only while enable bit 0 is set; reset clears it.
// - mode bit picks pump source: 0 volumes, 1 real-time audio level.
// - volume mode derives pump mode from four headphone and line volumes.
// - mode bit resets to zero, so pump starts in volume mode.
// - pump uses system clock plus 4 kHz tick; needs 2.8224 MHz minimum.
// - pump clock divides system clock to nominal 1 MHz by chosen ratio.
// - ratio 12 at 256 times sample rate, 6 at 128 times.
// - ratio is picked automatically from clock settings, no software field.
// - enabled pump adapts rail level and switching rate to chosen source.
// - start-up sequence sets pump enable; shut-down sequence clears it.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module lcp_control
#(
  parameter int unsigned VOL_W = 6
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [lcp_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [lcp_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // sequencer requests
  input wire logic sequence_pump_on,
  input wire logic sequence_pump_off,
  // clock settings
  input wire logic [3:0] system_clock_ratio_select,
  // level sources
  input wire logic [VOL_W-1:0] left_headphone_volume,
  input wire logic [VOL_W-1:0] right_headphone_volume,
  input wire logic [VOL_W-1:0] left_line_volume,
  input wire logic [VOL_W-1:0] right_line_volume,
  input wire logic [7:0] audio_level,
  // line output stages
  output logic left_line_short_release,
  output logic left_line_output_stage_on,
  output logic left_line_middle_stage_on,
  output logic left_line_input_stage_on,
  output logic right_line_short_release,
  output logic right_line_output_stage_on,
  output logic right_line_middle_stage_on,
  output logic right_line_input_stage_on,
  // charge pump
  output logic pump_enable,
  output logic pump_level_tracking_select,
  output logic pump_clock,
  output logic pump_tick,
  output logic pump_full_rail
);
  import lcp_pkg::*;

  // ****************
  // declarations
  // ****************
  logic [7:0] lineout_stage_control;
  logic charge_pump_enable;
  logic charge_pump_power_mode;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] data_q;
  logic strb_q;
  logic clock_ok;
  lcp_pump_if pump ();

  // one-hot select: lineout, enable, mode, status
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    if (addr == LINEOUT_ADDR)
      sel = 4'h1;
    else if (addr == PUMP_ENABLE_ADDR)
      sel = 4'h2;
    else if (addr == PUMP_MODE_ADDR)
      sel = 4'h4;
    else if (addr == PUMP_STATUS_ADDR)
      sel = 4'h8;
    return sel;
  endfunction : decode

  // ratio tracks the system clock multiple in steps of 64 fs
  function automatic logic [RATIO_W-1:0] pump_ratio(input logic [3:0] rate);
    return RATIO_W'(RATIO_STEP * ({2'b00, rate} + 6'h01));
  endfunction : pump_ratio

  // ****************
  // write channel
  // ****************
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire do_write = have_aw && have_w && !bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_held ? addr_q : awaddr;
  wire [31:0] wr_data = w_held ? data_q : wdata;
  wire wr_lane0 = w_held ? strb_q : wstrb[0];
  wire [3:0] wr_sel = decode(wr_addr);
  wire wr_lineout = do_write && wr_sel[0] && wr_lane0;
  wire wr_enable = do_write && wr_sel[1] && wr_lane0;
  wire wr_mode = do_write && wr_sel[2] && wr_lane0;
  wire wr_hit = |wr_sel;

  // no new beat while a response waits, so one write stays in flight
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      strb_q <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        addr_q <= awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        data_q <= wdata;
        strb_q <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // ****************
  // control registers
  // ****************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lineout_stage_control <= LINEOUT_RESET;
      charge_pump_power_mode <= PUMP_TRACK_RESET;
    end
    else
    begin
      if (wr_lineout)
        lineout_stage_control <= wr_data[7:0];
      if (wr_mode)
        charge_pump_power_mode <= wr_data[PUMP_TRACK_BIT];
    end
  end

  // sequencer request outranks a bus write landing in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      charge_pump_enable <= PUMP_ENABLE_RESET;
    else if (sequence_pump_on)
      charge_pump_enable <= 1'b1;
    else if (sequence_pump_off)
      charge_pump_enable <= 1'b0;
    else if (wr_enable)
      charge_pump_enable <= wr_data[PUMP_ENABLE_BIT];
  end

  // ****************
  // read channel
  // ****************
  wire [3:0] rd_sel = decode(araddr);
  wire [31:0] status_word = {24'h00_0000, pump.ratio, pump_full_rail, pump_enable};
  wire [31:0] rd_word = rd_sel[0] ? {24'h00_0000, lineout_stage_control} :
                        rd_sel[1] ? {31'h0000_0000, charge_pump_enable} :
                        rd_sel[2] ? {31'h0000_0000, charge_pump_power_mode} :
                        rd_sel[3] ? status_word : 32'h0000_0000;

  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= (|rd_sel) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // ****************
  // stage outputs
  // ****************
  // each bit goes straight to its stage; pop-free order is left to software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left_line_short_release <= 1'b0;
      left_line_output_stage_on <= 1'b0;
      left_line_middle_stage_on <= 1'b0;
      left_line_input_stage_on <= 1'b0;
      right_line_short_release <= 1'b0;
      right_line_output_stage_on <= 1'b0;
      right_line_middle_stage_on <= 1'b0;
      right_line_input_stage_on <= 1'b0;
    end
    else
    begin
      left_line_short_release <= lineout_stage_control[LEFT_SHORT_BIT];
      left_line_output_stage_on <= lineout_stage_control[LEFT_OUTPUT_BIT];
      left_line_middle_stage_on <= lineout_stage_control[LEFT_MIDDLE_BIT];
      left_line_input_stage_on <= lineout_stage_control[LEFT_INPUT_BIT];
      right_line_short_release <= lineout_stage_control[RIGHT_SHORT_BIT];
      right_line_output_stage_on <= lineout_stage_control[RIGHT_OUTPUT_BIT];
      right_line_middle_stage_on <= lineout_stage_control[RIGHT_MIDDLE_BIT];
      right_line_input_stage_on <= lineout_stage_control[RIGHT_INPUT_BIT];
    end
  end

  // ****************
  // charge pump
  // ****************
  // a system clock below the floor would starve the pump, so it stays off
  assign clock_ok = (SYSCLK_HZ >= SYSCLK_MIN_HZ);
  assign pump.enable = charge_pump_enable && clock_ok;
  assign pump.tracking = charge_pump_power_mode;
  assign pump.ratio = pump_ratio(system_clock_ratio_select);

  lcp_clock_divider u_divider
  (
    .aclk (aclk),
    .aresetn (aresetn),
    .pump (pump.divider)
  );

  lcp_level_mode #(.VOL_W(VOL_W)) u_level
  (
    .aclk (aclk),
    .aresetn (aresetn),
    .left_headphone_volume (left_headphone_volume),
    .right_headphone_volume (right_headphone_volume),
    .left_line_volume (left_line_volume),
    .right_line_volume (right_line_volume),
    .audio_level (audio_level),
    .pump (pump.level)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pump_enable <= 1'b0;
      pump_level_tracking_select <= 1'b0;
      pump_clock <= 1'b0;
      pump_tick <= 1'b0;
      pump_full_rail <= 1'b0;
    end
    else
    begin
      pump_enable <= pump.enable;
      pump_level_tracking_select <= charge_pump_power_mode;
      pump_clock <= pump.pump_clock;
      pump_tick <= pump.tick;
      pump_full_rail <= (pump.rail == LCP_RAIL_FULL);
    end
  end

endmodule : lcp_control

// ==== tb/lcp_control_monitor.sv ====
// Purpose: port-level checks for the line output and pump control block
// Assumes: write address and data are offered together by the master
// Notes: a write whose halves are taken on different edges is not tracked
`timescale 1ns/1ns
module lcp_monitor
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus write side
  input wire logic [lcp_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  // sequencer
  input wire logic sequence_pump_on,
  input wire logic sequence_pump_off,
  // stage and pump outputs
  input wire logic left_line_short_release,
  input wire logic left_line_output_stage_on,
  input wire logic left_line_middle_stage_on,
  input wire logic left_line_input_stage_on,
  input wire logic right_line_short_release,
  input wire logic right_line_output_stage_on,
  input wire logic right_line_middle_stage_on,
  input wire logic right_line_input_stage_on,
  input wire logic pump_enable,
  input wire logic pump_level_tracking_select,
  input wire logic pump_tick,
  input wire logic pump_full_rail
);
  import lcp_pkg::*;
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr_take = awvalid && awready && wvalid && wready && wstrb[0];
  // register edge, then output flop: two edges from handshake to pin
  sequence s_write(logic [ADDR_W-1:0] a);
    wr_take && awaddr == a;
  endsequence
  a_left_short: assert property (
    s_write(LINEOUT_ADDR) |-> ##2 left_line_short_release == $past(wdata[7], 2))
    else $error("left short release does not follow the write");
  a_left_stages: assert property (
    s_write(LINEOUT_ADDR) |-> ##2 {left_line_output_stage_on, left_line_middle_stage_on,
    left_line_input_stage_on} == $past(wdata[6:4], 2))
    else $error("left stage enables do not follow the write");
  a_right_short: assert property (
    s_write(LINEOUT_ADDR) |-> ##2 right_line_short_release == $past(wdata[3], 2))
    else $error("right short release does not follow the write");
  a_right_stages: assert property (
    s_write(LINEOUT_ADDR) |-> ##2 {right_line_output_stage_on, right_line_middle_stage_on,
    right_line_input_stage_on} == $past(wdata[2:0], 2))
    else $error("right stage enables do not follow the write");
  a_enable_write: assert property (
    s_write(PUMP_ENABLE_ADDR) ##0 !sequence_pump_on && !sequence_pump_off
    |-> ##2 pump_enable == $past(wdata[0], 2))
    else $error("pump enable does not follow the write");
  a_mode_write: assert property (
    s_write(PUMP_MODE_ADDR) |-> ##2 pump_level_tracking_select == $past(wdata[0], 2))
    else $error("mode select does not follow the write");
  a_seq_start: assert property (
    sequence_pump_on |-> ##2 pump_enable)
    else $error("start request did not enable the pump");
  a_seq_stop: assert property (
    sequence_pump_off && !sequence_pump_on |-> ##2 !pump_enable)
    else $error("stop request did not disable the pump");
  a_tick_single: assert property (
    pump_tick |=> !pump_tick)
    else $error("slow tick wider than one cycle");
  a_idle_quiet: assert property (
    !pump_enable [*3] |-> !pump_tick && !pump_full_rail)
    else $error("disabled pump still ticks or holds full rail");
endmodule : lcp_monitor

bind lcp_control lcp_monitor u_monitor (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
  .wstrb, .wvalid, .wready, .sequence_pump_on, .sequence_pump_off, .left_line_short_release,
  .left_line_output_stage_on, .left_line_middle_stage_on, .left_line_input_stage_on,
  .right_line_short_release, .right_line_output_stage_on, .right_line_middle_stage_on,
  .right_line_input_stage_on, .pump_enable, .pump_level_tracking_select, .pump_tick,
  .pump_full_rail);

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the line output and pump control block
// Assumes: ratio code n gives a pump divide of 3*(n+1)
// Notes: pump waits are long because the rail decision moves only on the slow tick
`timescale 1ns/1ns
module testbench;
  import lcp_pkg::*;
  // ****************
  // signals
  // ****************
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sequence_pump_on = 1'b0, sequence_pump_off = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, d, seed = 32'hbc93;
  logic [3:0] wstrb = 4'h0, system_clock_ratio_select = 4'h3;
  logic [5:0] left_headphone_volume = 6'h00, right_headphone_volume = 6'h00;
  logic [5:0] left_line_volume = 6'h00, right_line_volume = 6'h00;
  logic [7:0] audio_level = 8'h00, line_out;
  logic awready, wready, bvalid, arready, rvalid, pump_enable, pump_level_tracking_select;
  logic pump_clock, pump_tick, pump_full_rail, left_line_short_release, left_line_output_stage_on;
  logic left_line_middle_stage_on, left_line_input_stage_on, right_line_short_release;
  logic right_line_output_stage_on, right_line_middle_stage_on, right_line_input_stage_on;
  logic [1:0] bresp, rresp;
  logic [31:0] corner [7] = '{32'h0000_0011, 32'h0000_0033, 32'h0000_0077, 32'h0000_00ff,
    32'h0000_0077, 32'h0000_0000, 32'hffff_ff00};
  int failures = 0, checks = 0, n;
  assign line_out = {left_line_short_release, left_line_output_stage_on,
    left_line_middle_stage_on, left_line_input_stage_on, right_line_short_release,
    right_line_output_stage_on, right_line_middle_stage_on, right_line_input_stage_on};
  always #10 aclk = ~aclk;
  lcp_control dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .sequence_pump_on, .sequence_pump_off, .system_clock_ratio_select,
    .left_headphone_volume, .right_headphone_volume, .left_line_volume, .right_line_volume,
    .audio_level, .left_line_short_release, .left_line_output_stage_on,
    .left_line_middle_stage_on, .left_line_input_stage_on, .right_line_short_release,
    .right_line_output_stage_on, .right_line_middle_stage_on, .right_line_input_stage_on,
    .pump_enable, .pump_level_tracking_select, .pump_clock, .pump_tick, .pump_full_rail);
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  function automatic int exp_ratio(input logic [3:0] code);
    return 3 * (int'(code) + 1);
  endfunction : exp_ratio
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic give_up();
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask : give_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one edge first, so a strobe lowered by the last call is never raised in the same step
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] v,
    input logic [3:0] s, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (k == 100)
      give_up();
    check(32'(bresp), 32'(er));
  endtask : axi_write
  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    if (k == 100)
      give_up();
    check(rdata, ed);
    check(32'(rresp), 32'(er));
  endtask : axi_read
  task automatic seq_pulse(input logic on, input logic off);
    sequence_pump_on <= on;
    sequence_pump_off <= off;
    @(posedge aclk);
    sequence_pump_on <= 1'b0;
    sequence_pump_off <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : seq_pulse
  task automatic wait_rail(input logic v);
    int k;
    for (k = 0; k < 9000 && pump_full_rail !== v; k++)
      @(posedge aclk);
    if (k == 9000)
      give_up();
  endtask : wait_rail
  // cycles between two rising edges of the pump clock (sel 0) or the tick (sel 1)
  task automatic measure(input logic sel, output int len);
    logic prev, cur;
    int k, first;
    prev = 1'b1;
    first = -1;
    len = 0;
    for (k = 0; k < 8000 && len == 0; k++)
    begin
      @(posedge aclk);
      cur = sel ? pump_tick : pump_clock;
      if (cur && !prev && first >= 0)
        len = k - first;
      else if (cur && !prev)
        first = k;
      prev = cur;
    end
    if (len == 0)
      give_up();
  endtask : measure
  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    check(32'(line_out), 32'h0000_0000);
    axi_read(LINEOUT_ADDR, 32'h0000_0000, RESP_OKAY);
    axi_read(PUMP_ENABLE_ADDR, 32'h0000_0000, RESP_OKAY);
    axi_read(PUMP_MODE_ADDR, 32'h0000_0000, RESP_OKAY);
    check(32'(pump_level_tracking_select), 32'h0000_0000);
    $display("test reset values done");
    // pop-free enable order, pop-free disable order, upper bits, then random words
    for (int i = 0; i < 16; i++)
    begin
      d = (i < 7) ? corner[i] : next_rand();
      axi_write(LINEOUT_ADDR, d, 4'hf, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(line_out), 32'(d[7:0]));
      axi_read(LINEOUT_ADDR, 32'(d[7:0]), RESP_OKAY);
    end
    axi_write(LINEOUT_ADDR, 32'h0000_00aa, 4'h0, RESP_OKAY);
    axi_read(LINEOUT_ADDR, 32'(d[7:0]), RESP_OKAY);
    axi_write(12'h004, 32'h0000_00ff, 4'hf, RESP_SLVERR);
    axi_read(12'h004, 32'h0000_0000, RESP_SLVERR);
    $display("test line stages done");
    axi_write(PUMP_ENABLE_ADDR, 32'hffff_fff1, 4'hf, RESP_OKAY);
    axi_read(PUMP_ENABLE_ADDR, 32'h0000_0001, RESP_OKAY);
    seq_pulse(1'b0, 1'b1);
    check(32'(pump_enable), 32'h0000_0000);
    seq_pulse(1'b1, 1'b1);
    check(32'(pump_enable), 32'h0000_0001);
    for (int v = 1; v >= 0; v--)
    begin
      axi_write(PUMP_MODE_ADDR, 32'(v), 4'hf, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(pump_level_tracking_select), 32'(v));
      axi_read(PUMP_MODE_ADDR, 32'(v), RESP_OKAY);
    end
    $display("test pump registers done");
    for (int j = 0; j < 2; j++)
    begin
      seq_pulse(1'b0, 1'b1);
      system_clock_ratio_select <= j ? 4'h1 : 4'h3;
      left_headphone_volume <= 6'h30;
      right_line_volume <= 6'(next_rand()) & 6'h2f;
      audio_level <= 8'(next_rand());
      seq_pulse(1'b1, 1'b0);
      wait_rail(1'b1);
      check(32'(pump_full_rail), 32'h0000_0001);
      measure(1'b0, n);
      check(32'(n), 32'(exp_ratio(system_clock_ratio_select)));
      measure(1'b1, n);
      check(32'(n), 32'(PUMP_PER_TICK * exp_ratio(system_clock_ratio_select)));
      d = 32'({6'(exp_ratio(system_clock_ratio_select)), 2'b11});
      axi_read(PUMP_STATUS_ADDR, d, RESP_OKAY);
    end
    left_headphone_volume <= 6'h2f;
    audio_level <= 8'hff;
    wait_rail(1'b0);
    check(32'(pump_full_rail), 32'h0000_0000);
    axi_write(PUMP_MODE_ADDR, 32'h0000_0001, 4'hf, RESP_OKAY);
    audio_level <= 8'h40;
    left_line_volume <= 6'(next_rand());
    wait_rail(1'b1);
    check(32'(pump_full_rail), 32'h0000_0001);
    audio_level <= 8'h3f;
    wait_rail(1'b0);
    check(32'(pump_full_rail), 32'h0000_0000);
    seq_pulse(1'b0, 1'b1);
    repeat (3) @(posedge aclk);
    check(32'(pump_enable), 32'h0000_0000);
    $display("test pump clock and rail done");
    give_verdict();
  end
endmodule : testbench
